// *** logic/tiop_axil.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tiop_defines.svh"
module tiop_axil (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    tiop_rbus_if.slave rb
);
    logic aw_got;
    logic w_got;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] s_q;
    logic aw_now;
    logic w_now;

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready = !w_got && !s_axi_bvalid;
    assign aw_now = aw_got | (s_axi_awvalid & s_axi_awready);
    assign w_now = w_got | (s_axi_wvalid & s_axi_wready);
    assign rb.wr = aw_now & w_now & !s_axi_bvalid;
    assign rb.waddr = aw_got ? aw_q : s_axi_awaddr;
    assign rb.wdata = w_got ? w_q : s_axi_wdata;
    assign rb.wstrb = w_got ? s_q : s_axi_wstrb;
    assign s_axi_arready = !s_axi_rvalid;
    assign rb.rd = s_axi_arvalid & s_axi_arready;
    assign rb.raddr = s_axi_araddr;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            s_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TIOP_RESP_OKAY;
        end else begin
            if (rb.wr) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1; // (R4)
                s_axi_bresp <= rb.werr ? `TIOP_RESP_SLVERR : `TIOP_RESP_OKAY;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got <= 1'b1;
                    aw_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got <= 1'b1;
                    w_q <= s_axi_wdata;
                    s_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TIOP_RESP_OKAY;
        end else if (rb.rd) begin
            s_axi_rvalid <= 1'b1; // (R4)
            s_axi_rdata <= rb.rdata;
            s_axi_rresp <= rb.rerr ? `TIOP_RESP_SLVERR : `TIOP_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_rd_one;
        @(posedge mclk) disable iff (sys_rst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_one: assert property (p_rd_one) else $error("read late"); // (R4)

    property p_wr_one;
        @(posedge mclk) disable iff (sys_rst)
        rb.wr |=> s_axi_bvalid && !s_axi_awready;
    endproperty
    a_wr_one: assert property (p_wr_one) else $error("write late"); // (R4)
endmodule
`default_nettype wire

// *** logic/tiop_clkblk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tiop_defines.svh"
module tiop_clkblk (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // configuration
    input wire logic use_pin,
    input wire logic src_pin,
    input wire logic [7:0] div,
    // port clock edge
    output logic tick
);
    logic pin_q;
    logic edge_ok;
    logic [7:0] dcnt;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= src_pin;
        end
    end

    // rising edge of the 1-bit port, or every reference cycle
    assign edge_ok = use_pin ? (src_pin & ~pin_q) : 1'b1; // (R16)
    assign tick = edge_ok && (dcnt >= div); // (R15) (R17)

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dcnt <= 8'h00;
        end else if (edge_ok) begin
            dcnt <= (dcnt >= div) ? 8'h00 : dcnt + 8'h01; // (R17)
        end
    end
endmodule
`default_nettype wire

// *** logic/tiop_defines.svh ***
`ifndef TIOP_DEFINES_SVH
`define TIOP_DEFINES_SVH
// How it works
// (R1) ports of 1, 4, 8, 16 or 32 bits join the tile to pins; here only port a (4 bits) and port b (1 bit)
// (R2) all pins of one port share one direction
// (R3) pins driven high or low or sampled, optionally waiting on a condition
// (R4) each port access by the processor completes in one cycle
// (R5) open-collector: zero drives low, one leaves the pin floating
// (R6) data moves through a serialiser and a transfer register; here only the transfer register xfer, with no serialiser
// (R7) each port has a 16-bit counter scheduling transfers
// (R8) counter readable any time; transfers may wait for a future count
// (R9) each transfer captures the counter as a timestamp
// (R10) pin events go straight to the scheduler, not as interrupts
// (R11) an enabled link disables the pins of its underlying ports
// (R12) narrower enabled port wins shared pins; unshared pins stay usable
// (R13) a port always transfers at its own width
// (R14) six clock blocks; block 0 is the 100 MHz reference
// (R15) blocks 1 to 5 run at programmable independent rates
// (R16) a clock block may be paced by a 1-bit port pin
// (R17) a clock block may divide its 1-bit port clock
// (R18) ports accept an input strobe and can drive an output strobe
// (R19) after reset every port uses clock block 0
// (R20) port counter steps once per port clock edge and wraps
// (R21) conditional input completes on first edge meeting the condition
`define TIOP_NCB 6
`define TIOP_MCLK_PERIOD_NS 10
`define TIOP_REF_PERIOD_NS 10
`define TIOP_REF_DIV (`TIOP_REF_PERIOD_NS / `TIOP_MCLK_PERIOD_NS - 1)
`define TIOP_PORT_STRIDE 8'h10
`define TIOP_OFS_CTRL 8'h00
`define TIOP_OFS_DATA 8'h04
`define TIOP_OFS_TIME 8'h08
`define TIOP_OFS_STAT 8'h0C
`define TIOP_CB_BASE 8'h20
`define TIOP_LINK 8'h40
`define TIOP_C_EN 0
`define TIOP_C_OUT 1
`define TIOP_C_OC 2
`define TIOP_C_CLK 3
`define TIOP_C_COND 6
`define TIOP_C_TIMED 8
`define TIOP_C_STB 9
`define TIOP_C_VAL 16
`define TIOP_CB_PIN 0
`define TIOP_CB_DIV 8
`define TIOP_RESP_OKAY 2'b00
`define TIOP_RESP_SLVERR 2'b10
`endif

// *** logic/tiop_pkg.sv ***
`default_nettype none
package tiop_pkg;
    typedef enum logic [1:0] {
        TIOP_COND_NONE,
        TIOP_COND_EQ,
        TIOP_COND_NEQ
    } tiop_cond_t;
    typedef logic [15:0] tiop_cnt_t;
endpackage
`default_nettype wire

// *** logic/tiop_rbus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tiop_rbus_if;
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic werr;
    logic rd;
    logic [7:0] raddr;
    logic [31:0] rdata;
    logic rerr;
    modport slave(output wr, waddr, wdata, wstrb, rd, raddr,
                  input werr, rdata, rerr);
    modport regs(input wr, waddr, wdata, wstrb, rd, raddr,
                 output werr, rdata, rerr);
endinterface
`default_nettype wire

// *** logic/tiop_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tiop_defines.svh"
module tiop_top (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [3:0] pin_i,
    output logic [3:0] pin_o,
    output logic [3:0] pin_oe,
    // strobes, scheduler events, link
    input wire logic strobe_in,
    output logic output_strobe,
    output logic [1:0] port_event,
    output logic link_active
);
    tiop_rbus_if rb();
    tiop_axil i_tiop_axil (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rb(rb)
    );
    logic [31:0] ctrl [2];
    logic [15:0] target [2];
    logic [31:0] cbcfg [`TIOP_NCB];
    logic link_en;
    tiop_pkg::tiop_cnt_t cnt [2];
    tiop_pkg::tiop_cnt_t ts [2];
    logic [3:0] xfer [2];
    logic [3:0] outv [2];
    logic [3:0] pins_in [2];
    logic [3:0] po [2];
    logic [3:0] oe [2];
    logic pend [2];
    logic done [2];
    logic fire [2];
    logic tick_p [2];
    logic stb [2];
    logic ev [2];
    logic go [2];
    logic [5:0] ticks;
    logic [7:0] ticks8;
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[8*i +: 8] = n[8*i +: 8];
            end
        end
        return m;
    endfunction
    function automatic logic [7:0] preg(input int p, input logic [7:0] off);
        return 8'(`TIOP_PORT_STRIDE * p) + off;
    endfunction
    function automatic logic [7:0] cbreg(input int k);
        return 8'(`TIOP_CB_BASE + 4 * k);
    endfunction
    function automatic logic addr_ok(input logic [7:0] a);
        logic ok;
        ok = (a == `TIOP_LINK);
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 4; r++) begin
                ok = ok | (a == preg(p, 8'(4 * r)));
            end
        end
        for (int k = 0; k < `TIOP_NCB; k++) begin
            ok = ok | (a == cbreg(k));
        end
        return ok;
    endfunction
    // register writes; block 0 config stays zero, it is the reference
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int p = 0; p < 2; p++) begin
                ctrl[p] <= 32'h0000_0000; // (R19)
                target[p] <= 16'h0000;
            end
            for (int k = 0; k < `TIOP_NCB; k++) begin
                cbcfg[k] <= 32'h0000_0000;
            end
            link_en <= 1'b0;
        end else if (rb.wr) begin
            for (int p = 0; p < 2; p++) begin
                if (rb.waddr == preg(p, `TIOP_OFS_CTRL)) begin
                    ctrl[p] <= merge(ctrl[p], rb.wdata, rb.wstrb);
                end
                if (rb.waddr == preg(p, `TIOP_OFS_TIME)) begin
                    target[p] <= 16'(merge({16'h0000, target[p]},
                                           rb.wdata, rb.wstrb)); // (R8)
                end
            end
            for (int k = 1; k < `TIOP_NCB; k++) begin
                if (rb.waddr == cbreg(k)) begin
                    cbcfg[k] <= merge(cbcfg[k], rb.wdata, rb.wstrb); // (R15)
                end
            end
            if (rb.waddr == `TIOP_LINK && rb.wstrb[0]) begin
                link_en <= rb.wdata[0];
            end
        end
    end
    assign rb.werr = !addr_ok(rb.waddr);
    assign rb.rerr = !addr_ok(rb.raddr);
    always_comb begin
        rb.rdata = 32'h0000_0000;
        for (int p = 0; p < 2; p++) begin
            if (rb.raddr == preg(p, `TIOP_OFS_CTRL)) begin
                rb.rdata = ctrl[p];
            end
            if (rb.raddr == preg(p, `TIOP_OFS_DATA)) begin
                rb.rdata = {28'h000_0000, xfer[p]};
            end
            if (rb.raddr == preg(p, `TIOP_OFS_TIME)) begin
                rb.rdata = {16'h0000, ts[p]}; // (R9)
            end
            if (rb.raddr == preg(p, `TIOP_OFS_STAT)) begin
                rb.rdata = {14'h0000, done[p], pend[p], cnt[p]}; // (R8)
            end
        end
        for (int k = 0; k < `TIOP_NCB; k++) begin
            if (rb.raddr == cbreg(k)) begin
                rb.rdata = cbcfg[k];
            end
        end
        if (rb.raddr == `TIOP_LINK) begin
            rb.rdata = {31'h0000_0000, link_en};
        end
    end
    // port b pin paces any block set to pin mode
    genvar k;
    generate
        for (k = 0; k < `TIOP_NCB; k++) begin : g_cb
            tiop_clkblk i_tiop_clkblk (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .use_pin(k != 0 && cbcfg[k][`TIOP_CB_PIN]), // (R16)
                .src_pin(pin_i[0]),
                .div(k == 0 ? 8'(`TIOP_REF_DIV)
                            : cbcfg[k][`TIOP_CB_DIV +: 8]), // (R14)
                .tick(ticks[k])
            );
        end
    endgenerate
    // selections 6 and 7 name no block and hold the port still
    assign ticks8 = {2'b00, ticks};
    assign pins_in[0] = pin_i; // (R13)
    assign pins_in[1] = {3'b000, pin_i[0]};
    default clocking cb_m @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            localparam int W = (p == 0) ? 4 : 1; // (R1)
            localparam logic [3:0] MASK = 4'((1 << W) - 1);
            logic en;
            logic out;
            logic oc;
            logic timed;
            logic stben;
            logic cond_ok;
            logic [3:0] cval;
            tiop_pkg::tiop_cond_t cond;
            assign en = ctrl[p][`TIOP_C_EN];
            assign out = ctrl[p][`TIOP_C_OUT];
            assign oc = ctrl[p][`TIOP_C_OC];
            assign timed = ctrl[p][`TIOP_C_TIMED];
            assign stben = ctrl[p][`TIOP_C_STB];
            assign cval = ctrl[p][`TIOP_C_VAL +: 4] & MASK;
            assign cond = tiop_pkg::tiop_cond_t'(ctrl[p][`TIOP_C_COND +: 2]);
            assign tick_p[p] = ticks8[ctrl[p][`TIOP_C_CLK +: 3]];
            assign go[p] = rb.wr && rb.waddr == preg(p, `TIOP_OFS_DATA);
            always_comb begin
                case (cond)
                    tiop_pkg::TIOP_COND_NONE: cond_ok = 1'b1;
                    tiop_pkg::TIOP_COND_EQ:
                        cond_ok = (pins_in[p] & MASK) == cval; // (R3)
                    tiop_pkg::TIOP_COND_NEQ:
                        cond_ok = (pins_in[p] & MASK) != cval;
                    default: cond_ok = 1'b1;
                endcase
            end
            // a transfer fires on a port clock edge once all waits clear
            assign fire[p] = pend[p] && tick_p[p] && en
                && (!timed || cnt[p] == target[p]) // (R8)
                && (out || (cond_ok && (!stben || strobe_in))); // (R18) (R21)

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    cnt[p] <= 16'h0000;
                end else if (tick_p[p]) begin
                    cnt[p] <= cnt[p] + 16'h0001; // (R7) (R20)
                end
            end
            // a new request in the firing cycle wins over the clear
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    pend[p] <= 1'b0;
                end else begin
                    pend[p] <= go[p] | (pend[p] & !fire[p]);
                end
            end
            // done is cleared by reading the data word
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    done[p] <= 1'b0;
                end else begin
                    done[p] <= fire[p] | (done[p] &
                        !(rb.rd && rb.raddr == preg(p, `TIOP_OFS_DATA)));
                end
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    xfer[p] <= 4'h0;
                end else if (go[p]) begin
                    xfer[p] <= rb.wdata[3:0] & MASK; // (R6) (R13)
                end else if (fire[p] && !out) begin
                    xfer[p] <= pins_in[p] & MASK; // (R6)
                end
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    outv[p] <= 4'h0;
                end else if (fire[p] && out) begin
                    outv[p] <= xfer[p]; // (R3)
                end
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    ts[p] <= 16'h0000;
                end else if (fire[p]) begin
                    ts[p] <= cnt[p]; // (R9)
                end
            end
            // event straight to the scheduler, no interrupt path
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    ev[p] <= 1'b0;
                end else begin
                    ev[p] <= fire[p]; // (R10)
                end
            end
            // strobe lasts one port clock period with the data
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    stb[p] <= 1'b0;
                end else if (tick_p[p]) begin
                    stb[p] <= fire[p] && out && stben; // (R18)
                end
            end
            // one direction bit for the whole port
            assign oe[p] = (en && out) ? (oc ? ~outv[p] & MASK : MASK)
                                       : 4'h0; // (R2) (R5)
            assign po[p] = oc ? 4'h0 : outv[p]; // (R5)
            // reset edge excluded: the counter is cleared to zero there, not stepped
            property p_cnt_step;
                tick_p[p] && !sys_rst |=> cnt[p] == $past(cnt[p]) + 16'h0001;
            endproperty
            a_cnt_step: assert property (p_cnt_step) // (R20)
                else $error("counter step");
            property p_ts_cap;
                fire[p] |=> ts[p] == $past(cnt[p]) && ev[p];
            endproperty
            a_ts_cap: assert property (p_ts_cap) // (R9)
                else $error("timestamp");
            property p_timed;
                fire[p] && timed |=> ts[p] == $past(target[p]);
            endproperty
            a_timed: assert property (p_timed) else $error("early"); // (R8)
            property p_cond;
                fire[p] && !out && !go[p] && cond == tiop_pkg::TIOP_COND_EQ
                    |=> xfer[p] == cval;
            endproperty
            a_cond: assert property (p_cond) else $error("cond"); // (R21)
            property p_oc;
                oc |-> (po[p] == 4'h0) && ((oe[p] & outv[p]) == 4'h0);
            endproperty
            a_oc: assert property (p_oc) else $error("drove high"); // (R5)
        end
    endgenerate

    // narrow port b owns pin 0 while enabled; an enabled link owns all
    always_comb begin
        pin_oe = 4'h0;
        pin_o = 4'h0;
        if (!link_en) begin // (R11)
            pin_oe = oe[0];
            pin_o = po[0];
            if (ctrl[1][`TIOP_C_EN]) begin
                pin_oe[0] = oe[1][0]; // (R12)
                pin_o[0] = po[1][0];
            end
        end
    end

    assign output_strobe = stb[0] | stb[1];
    assign port_event = {ev[1], ev[0]};
    assign link_active = link_en;

    property p_link_off;
        link_en |-> pin_oe == 4'h0 && pin_o == 4'h0;
    endproperty
    a_link_off: assert property (p_link_off) else $error("link pins"); // (R11)

    property p_narrow;
        !link_en && ctrl[1][`TIOP_C_EN]
            |-> pin_oe == {oe[0][3:1], oe[1][0]};
    endproperty
    a_narrow: assert property (p_narrow) else $error("pin owner"); // (R12)

    property p_rst_cb0;
        $past(sys_rst) |-> ctrl[0][`TIOP_C_CLK +: 3] == 3'd0
            && ctrl[1][`TIOP_C_CLK +: 3] == 3'd0;
    endproperty
    a_rst_cb0: assert property (p_rst_cb0) else $error("clock sel"); // (R19)

    property p_ref;
        ticks[0] [*8];
    endproperty
    a_ref: assert property (p_ref) else $error("ref clock"); // (R14)
endmodule
`default_nettype wire

// *** tb/timed_io_port_with_clock_blocks_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tiop_defines.svh"
module timed_io_port_with_clock_blocks_bench;
    logic mclk;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic [3:0] wstrb = 4'hf, pin_i, pin_o, pin_oe;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, strobe_in;
    logic output_strobe, link_active, saw_stb;
    logic [1:0] bresp, rresp, rs, port_event;
    logic [15:0] t;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int ev0 = 0, ev1 = 0, n;
    logic [31:0] ctl [3] = '{32'h0009_0041, 32'h0009_0081, 32'h0000_0201};
    logic [3:0] bad [3] = '{4'h3, 4'h9, 4'h5};
    logic [3:0] good [3] = '{4'h9, 4'h2, 4'h5};

    tiop_top i_tiop_top (.mclk(mclk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .strobe_in(strobe_in), .output_strobe(output_strobe),
        .port_event(port_event), .link_active(link_active));
    tiop_pins_model i_tiop_pins_model (.mclk(mclk), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_i(pin_i), .strobe_in(strobe_in));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (port_event[0]) ev0 <= ev0 + 1;
        if (port_event[1]) ev1 <= ev1 + 1;
        if (output_strobe) saw_stb <= 1'b1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // values are sampled at the falling edge, where they are settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic ta, tr;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task automatic wrk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, `TIOP_RESP_OKAY});
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rdr(8'h00, rd, rs);
        chk(rd, 32'h0000_0000);
        chk({28'h0, pin_oe}, 32'h0000_0000);
        wrk(8'h20, 32'h0000_0101);
        rdr(8'h20, rd, rs);
        chk(rd, 32'h0000_0000);
        rdr(8'h44, rd, rs);
        chk({30'h0, rs}, {30'h0, `TIOP_RESP_SLVERR});
        n = ev0;
        wrk(8'h00, 32'h0000_0003);
        wrk(8'h04, 32'h0000_0005);
        wait (ev0 > n);
        chk({24'h0, pin_oe, pin_o}, 32'h0000_00f5);
        n = ev0;
        wrk(8'h00, 32'h0000_0007);
        wrk(8'h04, 32'h0000_0005);
        wait (ev0 > n);
        chk({24'h0, pin_oe, pin_o & pin_oe}, 32'h0000_00a0);
        wrk(8'h00, 32'h0000_0103);
        rdr(8'h0C, rd, rs);
        t = rd[15:0] + 16'd40;
        wrk(8'h08, {16'h0, t});
        n = ev0;
        wrk(8'h04, 32'h0000_0006);
        wait (ev0 > n);
        rdr(8'h08, rd, rs);
        chk({16'h0, rd[15:0]}, {16'h0, t});
        foreach (ctl[i]) begin
            i_tiop_pins_model.drive(bad[i]);
            wrk(8'h00, ctl[i]);
            wrk(8'h04, 32'h0000_0000);
            n = ev0;
            repeat (20) @(posedge mclk);
            chk(32'(ev0 - n), 32'h0000_0000);
            i_tiop_pins_model.drive(good[i]);
            if (i == 2) i_tiop_pins_model.strobe(1'b1);
            wait (ev0 > n);
            rdr(8'h04, rd, rs);
            chk({28'h0, rd[3:0]}, {28'h0, good[i]});
        end
        i_tiop_pins_model.strobe(1'b0);
        n = ev0;
        wrk(8'h00, 32'h0000_0003);
        wrk(8'h04, 32'h0000_0000);
        wait (ev0 > n);
        saw_stb <= 1'b0;
        n = ev1;
        wrk(8'h10, 32'h0000_0203);
        wrk(8'h14, 32'h0000_0001);
        wait (ev1 > n);
        repeat (3) @(posedge mclk);
        chk({31'h0, saw_stb}, 32'h0000_0001);
        chk({24'h0, pin_oe, pin_o}, 32'h0000_00f1);
        wrk(8'h40, 32'h0000_0001);
        chk({27'h0, link_active, pin_oe}, 32'h0000_0010);
        wrk(8'h40, 32'h0000_0000);
        wrk(8'h10, 32'h0000_0000);
        i_tiop_pins_model.drive(4'h0);
        wrk(8'h24, 32'h0000_0101);
        wrk(8'h00, 32'h0000_0009);
        n = ev0;
        wrk(8'h04, 32'h0000_0000);
        repeat (30) @(posedge mclk);
        chk(32'(ev0 - n), 32'h0000_0000);
        i_tiop_pins_model.pulse_clk(1);
        repeat (4) @(posedge mclk);
        chk(32'(ev0 - n), 32'h0000_0000);
        i_tiop_pins_model.pulse_clk(1);
        repeat (4) @(posedge mclk);
        chk(32'(ev0 - n), 32'h0000_0001);
        conclude();
    end
endmodule
`default_nettype wire

// *** tb/tiop_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tiop_pins_model (
    // clock
    input wire logic mclk,
    // device pins
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_i,
    // strobe
    output logic strobe_in
);
    logic [3:0] ext_v = 4'h0;
    logic ext_en = 1'b0;
    // undriven pins fall to the pull-down level
    assign pin_i = (pin_oe & pin_o)
        | (~pin_oe & (ext_en ? ext_v : 4'h0));
    initial strobe_in = 1'b0;
    task automatic drive(input logic [3:0] v);
        @(posedge mclk);
        ext_en <= 1'b1;
        ext_v <= v;
    endtask
    task automatic strobe(input logic s);
        @(posedge mclk);
        strobe_in <= s;
    endtask
    // clock on pin 0 stands still between bursts
    task automatic pulse_clk(input int n);
        repeat (2 * n) begin
            repeat (3) @(posedge mclk);
            ext_v[0] <= ~ext_v[0];
        end
    endtask
endmodule
`default_nettype wire
